//--- inc/asr_map.svh
// register offsets, field positions, reset values and counts of the soft reset controller
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH
`define ASR_OFS_CTRL 4'h0
`define ASR_OFS_STATUS 4'h1
`define ASR_OFS_RDLOG 4'h2
`define ASR_OFS_WRLOG 4'h3
`define ASR_OFS_NSPERMIT 4'h4
`define ASR_OFS_IRQ_STAT 4'h5
`define ASR_OFS_IRQ_MASK 4'h6
`define ASR_BIT_RESET 0
`define ASR_BIT_AUTO 1
`define ASR_BIT_ACT_RD 0
`define ASR_BIT_ACT_WR 1
`define ASR_BIT_RD_SEEN 2
`define ASR_BIT_WR_SEEN 3
`define ASR_FLD_EXIT_LO 4
`define ASR_FLD_EXIT_HI 5
`define ASR_RST_AUTO 1'b1
`define ASR_PROP_NS 40
`define ASR_PROP_CYC ((`ASR_PROP_NS + 9) / 10)
`define ASR_CNT_W 8
`define ASR_IRQ_ENTRY 0
`define ASR_IRQ_EXIT 1
`define ASR_IRQ_IGNORED 2
`define ASR_IRQ_W 3
`endif

//--- inc/asr_pkg.sv
// types of the soft reset controller
package asr_pkg;
  typedef enum logic [1:0] {
    ASR_RUN = 2'b00,
    ASR_PEND_ENTRY = 2'b01,
    ASR_IN_RESET = 2'b11,
    ASR_PEND_EXIT = 2'b10
  } asr_state_t;
  typedef enum logic [1:0] {
    ASR_EXIT_OK = 2'b00,
    ASR_EXIT_ERR = 2'b01,
    ASR_EXIT_BUSY = 2'b10,
    ASR_EXIT_BOTH = 2'b11
  } asr_exit_code_t;
endpackage

//--- inc/asr_log_if.sv
// bundle between the sequencer and the access log
`timescale 1ns/100ps
`default_nettype none
interface asr_log_if;
  logic clear;
  logic isolated;
  logic rd_seen;
  logic wr_seen;
  logic [31:0] rd_log;
  logic [31:0] wr_log;
  modport ctrl (output clear, output isolated, input rd_seen, input wr_seen, input rd_log, input wr_log);
  modport log (input clear, input isolated, output rd_seen, output wr_seen, output rd_log, output wr_log);
endinterface
`default_nettype wire

//--- core/asr_access_log.sv
// access origin log while the interface is isolated
`timescale 1ns/100ps
`default_nettype none
`include "asr_map.svh"
module asr_access_log
  import asr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // attempted accesses on the gated interface
  input wire logic rd_try,
  input wire logic [31:0] rd_origin,
  input wire logic wr_try,
  input wire logic wr_secure,
  input wire logic [31:0] wr_origin,
  // sequencer side
  asr_log_if.log lg
);
  typedef struct packed {
    logic rd_seen;
    logic wr_seen;
    logic [31:0] rd_log;
    logic [31:0] wr_log;
  } asr_log_state_t;
  asr_log_state_t st, next_st;

  always_comb begin
    next_st = st;
    // only the first read and the first secure write while isolated since the last clear are kept
    if (lg.isolated && rd_try && !st.rd_seen) begin
      next_st.rd_seen = 1'b1;
      next_st.rd_log = rd_origin;
    end
    if (lg.isolated && wr_try && wr_secure && !st.wr_seen) begin
      next_st.wr_seen = 1'b1;
      next_st.wr_log = wr_origin;
    end
    if (lg.clear) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lg.rd_seen = st.rd_seen;
  assign lg.wr_seen = st.wr_seen;
  assign lg.rd_log = st.rd_log;
  assign lg.wr_log = st.wr_log;
endmodule
`default_nettype wire

//--- core/asr_irq.sv
// sticky event bits, mask and level interrupt
`timescale 1ns/100ps
`default_nettype none
`include "asr_map.svh"
module asr_irq
  import asr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // events and software access
  input wire logic [`ASR_IRQ_W-1:0] events,
  input wire logic [`ASR_IRQ_W-1:0] clr_ones,
  input wire logic mask_we,
  input wire logic [`ASR_IRQ_W-1:0] mask_wdata,
  // state
  output logic [`ASR_IRQ_W-1:0] status,
  output logic [`ASR_IRQ_W-1:0] mask,
  output logic irq
);
  typedef struct packed {
    logic [`ASR_IRQ_W-1:0] status;
    logic [`ASR_IRQ_W-1:0] mask;
    logic irq;
  } asr_irq_state_t;
  asr_irq_state_t st, next_st;

  always_comb begin
    next_st = st;
    // set beats clear in the same cycle
    next_st.status = (st.status & ~clr_ones) | events;
    if (mask_we) begin
      next_st.mask = mask_wdata;
    end
    next_st.irq = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign status = st.status;
  assign mask = st.mask;
  assign irq = st.irq;
endmodule
`default_nettype wire

//--- core/asr_soft_reset_ctrl.sv
// soft reset sequencer for a device attached to one network interface
`timescale 1ns/100ps
`default_nettype none
`include "asr_map.svh"
module asr_soft_reset_ctrl
  import asr_pkg::*;
#(
  parameter bit RST_ACTIVE_HIGH = 1'b0,
  parameter bit ISOLATION_EN = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_secure,
  output logic [31:0] reg_rdata,
  // attached interface activity
  input wire logic rd_outstanding,
  input wire logic wr_outstanding,
  input wire logic err_pending,
  input wire logic rd_try,
  input wire logic [31:0] rd_origin,
  input wire logic wr_try,
  input wire logic wr_secure,
  input wire logic [31:0] wr_origin,
  // outputs to the attached device and the interrupt
  output logic if_gate,
  output logic dev_soft_reset,
  output logic irq
);
  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    asr_state_t fsm;
    logic auto_mode;
    logic nsp;
    logic in_reset;
    logic gate;
    logic pin;
    logic [`ASR_CNT_W-1:0] prop;
    logic [31:0] rdata;
    logic clr;
  } asr_ctrl_state_t;
  asr_ctrl_state_t st, next_st;

  asr_log_if lg ();
  logic [`ASR_IRQ_W-1:0] ev, clr_ones, irq_status, irq_mask;
  logic irq_int, mask_we;
  logic wr_ctrl, drained;
  logic [31:0] rd_word;
  asr_exit_code_t exit_code;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic status_ok(input logic sec, input logic permit);
    status_ok = ISOLATION_EN && (sec || permit);
  endfunction

  assign wr_ctrl = reg_wr && hit(reg_addr, `ASR_OFS_CTRL);
  assign drained = !rd_outstanding && !wr_outstanding;
  assign mask_we = reg_wr && hit(reg_addr, `ASR_OFS_IRQ_MASK);
  assign clr_ones = (reg_wr && hit(reg_addr, `ASR_OFS_IRQ_STAT)) ? reg_wdata[`ASR_IRQ_W-1:0] : '0;

  always_comb begin
    exit_code = asr_exit_code_t'({!drained, err_pending});
    if (st.fsm != ASR_PEND_EXIT) begin
      exit_code = ASR_EXIT_OK;
    end
  end

  // ***********************************************************
  // sequencer
  // ***********************************************************
  always_comb begin
    next_st = st;
    next_st.clr = 1'b0;
    // read word comes from its own process; one writer of the state copy
    next_st.rdata = rd_word;
    ev = '0;
    if (st.prop != '0) begin
      next_st.prop = st.prop - 1'b1;
    end
    if (reg_wr && hit(reg_addr, `ASR_OFS_NSPERMIT) && reg_secure) begin
      next_st.nsp = reg_wdata[0];
    end
    if (wr_ctrl) begin
      next_st.auto_mode = reg_wdata[`ASR_BIT_AUTO];
    end
    unique case (st.fsm)
      ASR_RUN: begin
        if (wr_ctrl && reg_wdata[`ASR_BIT_RESET]) begin
          next_st.fsm = ASR_PEND_ENTRY;
          next_st.gate = 1'b1;
        end
      end
      ASR_PEND_ENTRY, ASR_IN_RESET: begin
        if (wr_ctrl && reg_wdata[`ASR_BIT_RESET]) begin
          next_st.fsm = ASR_PEND_ENTRY;
          next_st.clr = 1'b1;
        end else if (wr_ctrl && st.fsm == ASR_PEND_ENTRY) begin
          ev[`ASR_IRQ_IGNORED] = 1'b1;
        end else if (wr_ctrl && st.prop == '0) begin
          next_st.fsm = ASR_PEND_EXIT;
        end else if (st.fsm == ASR_PEND_ENTRY && drained) begin
          next_st.fsm = ASR_IN_RESET;
          next_st.in_reset = 1'b1;
          // auto mode gates only; pin mode drives the pin
          next_st.pin = !st.auto_mode;
          next_st.prop = `ASR_CNT_W'(`ASR_PROP_CYC);
          ev[`ASR_IRQ_ENTRY] = 1'b1;
        end
      end
      ASR_PEND_EXIT: begin
        // rewrite of 0 restarts exit, 1 ignored
        if (wr_ctrl && !reg_wdata[`ASR_BIT_RESET]) begin
          next_st.clr = 1'b1;
        end else if (wr_ctrl) begin
          ev[`ASR_IRQ_IGNORED] = 1'b1;
        end else if (exit_code == ASR_EXIT_OK) begin
          next_st.fsm = ASR_RUN;
          next_st.in_reset = 1'b0;
          next_st.pin = 1'b0;
          next_st.gate = 1'b0;
          ev[`ASR_IRQ_EXIT] = 1'b1;
        end
      end
    endcase
  end

  // ***********************************************************
  // read path
  // ***********************************************************
  always_comb begin
    rd_word = '0;
    if (reg_rd) begin
      if (hit(reg_addr, `ASR_OFS_CTRL)) begin
        rd_word[`ASR_BIT_RESET] = st.in_reset;
        rd_word[`ASR_BIT_AUTO] = st.auto_mode;
      end else if (hit(reg_addr, `ASR_OFS_STATUS) && status_ok(reg_secure, st.nsp)) begin
        rd_word[`ASR_BIT_ACT_RD] = rd_outstanding;
        rd_word[`ASR_BIT_ACT_WR] = wr_outstanding;
        rd_word[`ASR_BIT_RD_SEEN] = lg.rd_seen;
        rd_word[`ASR_BIT_WR_SEEN] = lg.wr_seen;
        rd_word[`ASR_FLD_EXIT_HI:`ASR_FLD_EXIT_LO] = exit_code;
      end else if (hit(reg_addr, `ASR_OFS_RDLOG) && reg_secure) begin
        rd_word = lg.rd_log;
      end else if (hit(reg_addr, `ASR_OFS_WRLOG) && reg_secure) begin
        rd_word = lg.wr_log;
      end else if (hit(reg_addr, `ASR_OFS_NSPERMIT)) begin
        rd_word[0] = st.nsp;
      end else if (hit(reg_addr, `ASR_OFS_IRQ_STAT)) begin
        rd_word[`ASR_IRQ_W-1:0] = irq_status;
      end else if (hit(reg_addr, `ASR_OFS_IRQ_MASK)) begin
        rd_word[`ASR_IRQ_W-1:0] = irq_mask;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
      // auto mode on out of reset
      st.auto_mode <= `ASR_RST_AUTO;
    end else begin
      st <= next_st;
    end
  end

  assign lg.clear = st.clr;
  assign lg.isolated = st.gate;

  asr_access_log u_log (
    .clk(clk),
    .rstn(rstn),
    .rd_try(rd_try),
    .rd_origin(rd_origin),
    .wr_try(wr_try),
    .wr_secure(wr_secure),
    .wr_origin(wr_origin),
    .lg(lg)
  );

  asr_irq u_irq (
    .clk(clk),
    .rstn(rstn),
    .events(ev),
    .clr_ones(clr_ones),
    .mask_we(mask_we),
    .mask_wdata(reg_wdata[`ASR_IRQ_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq_int)
  );

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign reg_rdata = st.rdata;
  assign if_gate = st.gate;
  assign dev_soft_reset = st.pin ~^ RST_ACTIVE_HIGH;
  assign irq = irq_int;
endmodule
`default_nettype wire

//--- tb/asr_ctrl_asserts.sv
// port assertions of the soft reset controller
`timescale 1ns/100ps
`default_nettype none
module asr_ctrl_asserts #(
  parameter bit RST_ACTIVE_HIGH = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // attached side and outputs
  input wire logic rd_outstanding,
  input wire logic wr_outstanding,
  input wire logic err_pending,
  input wire logic if_gate,
  input wire logic dev_soft_reset
);
  logic auto_q;
  logic pin_on;
  logic ctl_wr;
  logic busy;
  assign pin_on = (dev_soft_reset == RST_ACTIVE_HIGH);
  assign ctl_wr = reg_wr && (reg_addr == 4'h0);
  assign busy = rd_outstanding || wr_outstanding || err_pending;
  // every control write reloads the mode bit
  always_ff @(posedge clk) begin
    if (!rstn) begin
      auto_q <= 1'b1;
    end else if (ctl_wr) begin
      auto_q <= reg_wdata[1];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  chk_entry_gates: assert property (ctl_wr && reg_wdata[0] && !if_gate |=> if_gate)
    else $error("entry request did not gate");
  chk_gate_hold: assert property (!if_gate && !ctl_wr |=> !if_gate)
    else $error("gated without a request");
  chk_ungate_drained: assert property ($past(rstn) && $fell(if_gate) |-> $past(!busy))
    else $error("ungated while busy");
  chk_pin_drained: assert property ($rose(pin_on) |-> $past(!rd_outstanding && !wr_outstanding))
    else $error("pin active before drain");
  chk_pin_hold: assert property (pin_on && busy |=> pin_on)
    else $error("pin released while busy");
  chk_pin_gated: assert property (pin_on |-> if_gate)
    else $error("pin active while ungated");
  chk_auto_pin: assert property (pin_on |-> !auto_q)
    else $error("pin active in auto mode");
endmodule
`default_nettype wire

//--- tb/asr_far_dev.sv
// attached device model: in-flight traffic and attempts on the gated port
`timescale 1ns/100ps
`default_nettype none
module asr_far_dev (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bench command
  input wire logic start,
  input wire logic [7:0] len,
  // controller side
  input wire logic if_gate,
  output logic rd_outstanding,
  output logic wr_outstanding,
  output logic rd_try,
  output logic [31:0] rd_origin,
  output logic wr_try,
  output logic wr_secure,
  output logic [31:0] wr_origin
);
  logic [7:0] cnt;
  logic [1:0] tries;
  logic [31:0] stamp;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt <= 8'h00;
      tries <= 2'h0;
      stamp <= 32'h0;
    end else begin
      stamp <= stamp + 32'h1;
      if (start) begin
        cnt <= len;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
      // one read then one write attempt per gating
      if (!if_gate) begin
        tries <= 2'h0;
      end else if (tries != 2'h3) begin
        tries <= tries + 2'h1;
      end
    end
  end
  assign rd_outstanding = (cnt != 8'h00);
  assign wr_outstanding = (cnt > 8'h02);
  assign rd_try = if_gate && (tries == 2'h1);
  assign wr_try = if_gate && (tries == 2'h2);
  assign wr_secure = 1'b1;
  // ids change every cycle, only meaningful with a try
  assign rd_origin = stamp;
  assign wr_origin = ~stamp;
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench of the soft reset controller
`timescale 1ns/100ps
`default_nettype none
`include "asr_map.svh"
module testbench;
  logic clk, rstn, reg_wr, reg_rd, reg_secure, err_pending, start, irq;
  logic rd_outstanding, wr_outstanding, rd_try, wr_try, wr_secure, if_gate, dev_soft_reset;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_origin, wr_origin, v;
  logic [7:0] len;
  int err_total, checked, m_auto, m_rst;
  asr_soft_reset_ctrl uut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_secure,
    .reg_rdata, .rd_outstanding, .wr_outstanding, .err_pending, .rd_try, .rd_origin, .wr_try,
    .wr_secure, .wr_origin, .if_gate, .dev_soft_reset, .irq);
  asr_far_dev far (.clk, .rstn, .start, .len, .if_gate, .rd_outstanding, .wr_outstanding,
    .rd_try, .rd_origin, .wr_try, .wr_secure, .wr_origin);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic busy(input int n);
    @(posedge clk);
    start <= 1'b1;
    len <= 8'(n);
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic poll(input int want);
    for (int i = 0; i < 40; i++) begin
      rd(4'h0, v);
      if (v[0] === want[0]) break;
    end
    m_rst = want;
    chk(v, 32'(m_auto * 2 + m_rst), "ctrl");
  endtask
  task automatic end_sim;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim;
  end
  initial begin
    {rstn, reg_wr, reg_rd, err_pending, start, len, reg_addr, reg_wdata} = '0;
    reg_secure = 1'b1;
    void'($urandom(32'hc15a));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    m_auto = 1;
    rd(4'h0, v);
    chk(v, 32'h2, "ctrl reset");
    rd(4'hF, v);
    chk(v, 32'h0, "unmapped");
    wr(4'h6, 32'h7);
    $display("reset values done");
    // pin mode: entry while traffic drains
    m_auto = 0;
    busy($urandom_range(14, 6));
    wr(4'h0, 32'h1);
    rd(4'h0, v);
    chk(v, 32'h0, "ctrl before drain");
    chk(if_gate, 1'b1, "gate");
    poll(1);
    chk(dev_soft_reset, 1'b0, "pin active");
    rd(4'h1, v);
    chk(v, 32'hC, "seen flags");
    wr(4'h0, 32'h1);
    rd(4'h1, v);
    chk(v, 32'h0, "seen cleared");
    poll(1);
    // software lets reset propagate before exit
    repeat (`ASR_PROP_CYC) @(posedge clk);
    err_pending <= 1'b1;
    wr(4'h0, 32'h0);
    rd(4'h1, v);
    chk(v[5:4], 2'b01, "exit code");
    wr(4'h0, 32'h1);
    rd(4'h0, v);
    chk(v, 32'h1, "ctrl pending exit");
    @(posedge clk);
    err_pending <= 1'b0;
    poll(0);
    chk({if_gate, dev_soft_reset}, 2'b01, "released");
    rd(4'h5, v);
    chk(v, 32'h7, "irq status");
    chk(irq, 1'b1, "irq up");
    wr(4'h5, 32'h7);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0, "irq cleared");
    $display("pin mode done");
    // auto mode: gate only, early exit ignored
    m_auto = 1;
    busy($urandom_range(14, 6));
    wr(4'h0, 32'h3);
    wr(4'h0, 32'h2);
    poll(1);
    chk({if_gate, dev_soft_reset}, 2'b11, "gate only");
    repeat (`ASR_PROP_CYC) @(posedge clk);
    wr(4'h0, 32'h2);
    poll(0);
    rd(4'h5, v);
    chk(v, 32'h7, "irq ignored");
    $display("auto mode done");
    // security of the status register
    busy(40);
    @(posedge clk);
    reg_secure <= 1'b0;
    rd(4'h1, v);
    chk(v, 32'h0, "nonsecure status");
    @(posedge clk);
    reg_secure <= 1'b1;
    wr(4'h4, 32'h1);
    @(posedge clk);
    reg_secure <= 1'b0;
    rd(4'h1, v);
    // seen flags of the auto run survive a plain exit
    chk(v, 32'hF, "permitted status");
    $display("security done");
    end_sim;
  end
endmodule
bind asr_soft_reset_ctrl asr_ctrl_asserts #(.RST_ACTIVE_HIGH(RST_ACTIVE_HIGH)) u_chk (.clk, .rstn,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rd_outstanding, .wr_outstanding,
  .err_pending, .if_gate, .dev_soft_reset);
`default_nettype wire
